// ---- design/slf_map.svh ----
/*
  Constants for the store-to-load forwarding check: sizes, address slices, queue depth.
  Assumes inclusion by the slf package and the design modules.
*/
`ifndef SLF_MAP_SVH
`define SLF_MAP_SVH
`define SLF_ADDR_W     48
`define SLF_DATA_W     64
`define SLF_ENTRIES    8
`define SLF_IDX_W      3
`define SLF_TAG_W      8
`define SLF_MATCH_HI   11
`define SLF_MATCH_LO   2
`define SLF_SIZE_1     2'h0
`define SLF_SIZE_2     2'h1
`define SLF_SIZE_4     2'h2
`define SLF_SIZE_8     2'h3
`endif

// ---- design/slf_pkg.sv ----
/*
  Types for the store-to-load forwarding check.
  Assumes slf_map.svh is on the include path.
*/
`default_nettype none
`include "slf_map.svh"
package slf_pkg;
  typedef logic [1:0] slf_size_t;
  typedef enum logic [1:0] {SLF_IDLE, SLF_HOLD, SLF_READ} slf_state_t;
endpackage
`default_nettype wire

// ---- design/slf_store_mem.sv ----
/*
  Store data storage of the second_level_load_store_queue, registered read port.
  Assumes one write and one read per cycle on the core clock.
*/
`default_nettype none
`include "slf_map.svh"
module slf_store_mem (
  input  wire logic                     clk,
  input  wire logic                     we,
  input  wire logic [`SLF_IDX_W-1:0]    waddr,
  input  wire logic [`SLF_DATA_W-1:0]   wdata,
  input  wire logic [`SLF_IDX_W-1:0]    raddr,
  output logic      [`SLF_DATA_W-1:0]   rdata
);
  logic [`SLF_DATA_W-1:0] mem_q [`SLF_ENTRIES];
  always_ff @(posedge clk) begin
    if (we) begin
      mem_q[waddr] <= wdata;
    end
    rdata <= mem_q[raddr];
  end
endmodule // slf_store_mem
`default_nettype wire

// ---- design/slf_check.sv ----
/*
  Store-to-load forwarding decision over a circular second_level_load_store_queue.
  Assumes: stores arrive in program order; the reorder buffer reports
  retire_ok when all instructions older than the oldest store have retired; the
  cache accepts one write per cycle; one load is presented at a time and held
  until load_done.
*/
`default_nettype none
`include "slf_map.svh"
module slf_check (
  input  wire logic                     clk,
  input  wire logic                     rst,
  input  wire logic                     st_valid,
  input  wire logic [`SLF_ADDR_W-1:0]   st_addr,
  input  wire slf_pkg::slf_size_t       st_size,
  input  wire logic                     st_high_byte,
  input  wire logic [`SLF_DATA_W-1:0]   st_data,
  input  wire logic                     retire_ok,
  input  wire logic                     ld_valid,
  input  wire logic [`SLF_ADDR_W-1:0]   ld_addr,
  input  wire slf_pkg::slf_size_t       ld_size,
  output logic                          st_ready,
  output logic                          cache_we,
  output logic      [`SLF_ADDR_W-1:0]   cache_addr,
  output logic      [`SLF_DATA_W-1:0]   cache_wdata,
  output slf_pkg::slf_size_t            cache_size,
  output logic                          cache_rd,
  output logic                          load_done,
  output logic                          load_fwd,
  output logic                          load_stall,
  output logic      [`SLF_DATA_W-1:0]   load_data
);
  // ****************************************
  // helpers
  // ****************************************
  function automatic logic aligned(input logic [`SLF_ADDR_W-1:0] a,
                                   input slf_pkg::slf_size_t s);
    unique case (s)
      `SLF_SIZE_1: aligned = 1'b1;
      `SLF_SIZE_2: aligned = (a[0] == 1'b0);
      `SLF_SIZE_4: aligned = (a[1:0] == 2'h0);
      default:     aligned = (a[2:0] == 3'h0);
    endcase
  endfunction

  // ****************************************
  // queue state
  // ****************************************
  logic [`SLF_ADDR_W-1:0] q_addr_q [`SLF_ENTRIES];
  slf_pkg::slf_size_t     q_size_q [`SLF_ENTRIES];
  logic                   q_hb_q   [`SLF_ENTRIES];
  logic [`SLF_ENTRIES-1:0] q_val_q;
  logic [`SLF_IDX_W-1:0]  head_q, tail_q;
  logic [`SLF_IDX_W:0]    count_q;
  logic                   push, pop;
  logic [`SLF_DATA_W-1:0] mem_rdata;
  logic [`SLF_IDX_W-1:0]  mem_raddr;

  slf_pkg::slf_state_t    state_q;
  logic [`SLF_IDX_W-1:0]  hit_idx_q;
  logic                   hit_any, hit_fwd;
  logic [`SLF_IDX_W-1:0]  hit_idx;
  logic                   narrow_q;

  assign push = st_valid && st_ready;
  // drain waits for a non-idle state so an idle search keeps the read port
  assign pop  = (count_q != '0) && retire_ok && (state_q != slf_pkg::SLF_IDLE);

  always_ff @(posedge clk) begin
    if (rst) begin
      st_ready <= 1'b1;
    end else begin
      st_ready <= ((count_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0))
                   < (`SLF_IDX_W+1)'(`SLF_ENTRIES - 1));
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      head_q  <= '0;
      tail_q  <= '0;
      count_q <= '0;
      q_val_q <= '0;
    end else begin
      if (push) begin
        tail_q <= tail_q + 1'b1;
        q_val_q[tail_q] <= 1'b1;
      end
      if (pop) begin
        head_q <= head_q + 1'b1;
        q_val_q[head_q] <= 1'b0;
      end
      count_q <= count_q + (push ? 1'b1 : 1'b0) - (pop ? 1'b1 : 1'b0);
    end
  end

  always_ff @(posedge clk) begin
    if (push) begin
      q_addr_q[tail_q] <= st_addr;
      q_size_q[tail_q] <= st_size;
      q_hb_q[tail_q]   <= st_high_byte;
    end
  end

  // memory read port: the cache drain reads head, a load reads its hit
  assign mem_raddr = (state_q == slf_pkg::SLF_IDLE) ? hit_idx : head_q;

  slf_store_mem u_mem (
    .clk   (clk),
    .we    (push),
    .waddr (tail_q),
    .wdata (st_data),
    .raddr (mem_raddr),
    .rdata (mem_rdata)
  );

  // ****************************************
  // cache write of the retiring entry
  // ****************************************
  // address travels one cycle with the registered data read
  logic                   pop_q;
  logic [`SLF_ADDR_W-1:0] pop_addr_q;
  slf_pkg::slf_size_t     pop_size_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      pop_q <= 1'b0;
    end else begin
      pop_q <= pop && (state_q != slf_pkg::SLF_IDLE);
    end
    pop_addr_q <= q_addr_q[head_q];
    pop_size_q <= q_size_q[head_q];
  end
  // drains are only allowed when the read port is free, i.e. not idle
  always_ff @(posedge clk) begin
    if (rst) begin
      cache_we    <= 1'b0;
      cache_addr  <= '0;
      cache_wdata <= '0;
      cache_size  <= `SLF_SIZE_1;
    end else begin
      cache_we <= pop_q;
      if (pop_q) begin
        cache_addr  <= pop_addr_q;
        cache_wdata <= mem_rdata;
        cache_size  <= pop_size_q;
      end
    end
  end

  // ****************************************
  // dependency search, newest first
  // ****************************************
  always_comb begin
    logic [`SLF_IDX_W-1:0] idx;
    hit_any = 1'b0;
    hit_idx = '0;
    idx     = '0;
    for (int i = 0; i < `SLF_ENTRIES; i++) begin
      idx = tail_q - (`SLF_IDX_W)'(i + 1);
      if (!hit_any && q_val_q[idx] &&
          q_addr_q[idx][`SLF_MATCH_HI:`SLF_MATCH_LO] ==
          ld_addr[`SLF_MATCH_HI:`SLF_MATCH_LO]) begin
        hit_any = 1'b1;
        hit_idx = idx;
      end
    end
  end

  always_comb begin
    hit_fwd = hit_any
      && (q_addr_q[hit_idx] == ld_addr)
      && (ld_size <= q_size_q[hit_idx])
      && aligned(ld_addr, ld_size)
      && aligned(q_addr_q[hit_idx], q_size_q[hit_idx])
      && !q_hb_q[hit_idx];
  end

  // ****************************************
  // load sequencing
  // ****************************************
  logic start_q;
  always_ff @(posedge clk) begin
    if (rst) begin
      state_q   <= slf_pkg::SLF_IDLE;
      hit_idx_q <= '0;
      narrow_q  <= 1'b0;
      start_q   <= 1'b0;
    end else begin
      start_q <= 1'b0;
      unique case (state_q)
        slf_pkg::SLF_IDLE: begin
          if (ld_valid && !load_done && !start_q) begin
            start_q   <= 1'b1;
            hit_idx_q <= hit_idx;
            narrow_q  <= hit_fwd;
            if (hit_any && !hit_fwd) begin
              state_q <= slf_pkg::SLF_HOLD;
            end
          end
        end
        slf_pkg::SLF_HOLD: begin
          // wait until the blocking entry has left and its cache write is out
          if (!q_val_q[hit_idx_q] && !pop_q && !cache_we) begin
            state_q <= slf_pkg::SLF_READ;
          end
        end
        slf_pkg::SLF_READ: state_q <= slf_pkg::SLF_IDLE;
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      load_done  <= 1'b0;
      load_fwd   <= 1'b0;
      load_stall <= 1'b0;
      load_data  <= '0;
      cache_rd   <= 1'b0;
    end else begin
      load_done <= 1'b0;
      load_fwd  <= 1'b0;
      cache_rd  <= 1'b0;
      load_stall <= (state_q == slf_pkg::SLF_HOLD);
      if (start_q && narrow_q) begin
        load_done <= 1'b1;
        load_fwd  <= 1'b1;
        load_data <= mem_rdata;
      end else if (start_q && state_q == slf_pkg::SLF_IDLE) begin
        cache_rd  <= 1'b1;
        load_done <= 1'b1;
      end else if (state_q == slf_pkg::SLF_READ) begin
        cache_rd  <= 1'b1;
        load_done <= 1'b1;
      end
    end
  end

  // ****************************************
  // checks
  // ****************************************
  sequence s_blocked;
    state_q == slf_pkg::SLF_HOLD;
  endsequence

  chk_fwd_addr_eq: assert property (@(posedge clk) disable iff (rst)
    (ld_valid && hit_fwd) |-> (q_addr_q[hit_idx] == ld_addr))
    else $error("forward with unequal start address");
  chk_fwd_width: assert property (@(posedge clk) disable iff (rst)
    (ld_valid && hit_fwd) |-> (ld_size <= q_size_q[hit_idx]))
    else $error("forward to wider load");
  chk_fwd_align: assert property (@(posedge clk) disable iff (rst)
    (ld_valid && hit_fwd) |-> aligned(ld_addr, ld_size))
    else $error("forward from misaligned access");
  chk_no_high_byte: assert property (@(posedge clk) disable iff (rst)
    (ld_valid && hit_any && q_hb_q[hit_idx]) |-> !hit_fwd)
    else $error("forward from upper byte store");
  chk_fwd_done: assert property (@(posedge clk) disable iff (rst)
    (state_q == slf_pkg::SLF_IDLE && ld_valid && !load_done && !start_q && hit_fwd)
      |=> ##1 (load_done && load_fwd))
    else $error("forwarded load not finished in two cycles");
  chk_hold_until_gone: assert property (@(posedge clk) disable iff (rst)
    s_blocked ##0 q_val_q[hit_idx_q] |=> !load_done)
    else $error("blocked load finished before store left");
  chk_drain_retire: assert property (@(posedge clk) disable iff (rst)
    cache_we |-> $past(retire_ok, 2))
    else $error("cache write without retirement");
  chk_pop_writes: assert property (@(posedge clk) disable iff (rst)
    pop |-> ##2 cache_we)
    else $error("retired entry never written to cache");
  chk_nonfwd_stall: assert property (@(posedge clk) disable iff (rst)
    s_blocked |=> (load_stall && !load_fwd))
    else $error("held load not flagged as stalled");
endmodule // slf_check
`default_nettype wire

// ---- tb/slf_core_model.sv ----
/*
  Far-side model of the forwarding check: reorder buffer retirement and data cache writes.
  Assumes the bench steers retirement through hold_retire and shares clk and rst.
*/
`default_nettype none
module slf_core_model (
  input  wire logic       clk,
  input  wire logic       rst,
  input  wire logic       hold_retire,
  input  wire logic       cache_we,
  output logic            retire_ok,
  output logic [7:0]      wr_count
);
  timeunit 1ns;
  timeprecision 1ns;
  // ************************************
  // retirement and cache
  // ************************************
  // slow reorder buffer: older work not yet retired while held
  assign retire_ok = !hold_retire;
  always_ff @(posedge clk) begin
    if (rst) wr_count <= 8'h00;
    else if (cache_we) wr_count <= wr_count + 8'h01;
  end
endmodule // slf_core_model
`default_nettype wire

// ---- tb/test_store_load_forward_check.sv ----
/*
  Self-checking bench for slf_check: table of store/load pairs, then a slow-retire case.
  Assumes slf_map.svh on the include path and slf_pkg compiled first.
*/
`default_nettype none
`include "slf_map.svh"
module test_store_load_forward_check;
  timeunit 1ns;
  timeprecision 1ns;
  typedef struct {
    logic [47:0] sa; slf_pkg::slf_size_t ss; logic hb;
    logic [47:0] la; slf_pkg::slf_size_t ls; logic fwd; logic dep;
  } slf_row_t;
  localparam logic [63:0] DATA = 64'h1122_3344_5566_7788;
  logic clk, rst, st_valid, st_high_byte, retire_ok, ld_valid, hold_retire;
  logic [47:0] st_addr, ld_addr, cache_addr;
  logic [63:0] st_data, cache_wdata, load_data;
  slf_pkg::slf_size_t st_size, ld_size, cache_size;
  logic st_ready, cache_we, cache_rd, load_done, load_fwd, load_stall;
  logic [7:0] wr_count;
  int failures = 0;
  int comparisons = 0;
  slf_row_t rows[10];
  // ************************************
  // instances and clock
  // ************************************
  slf_check dut (.clk(clk), .rst(rst), .st_valid(st_valid), .st_addr(st_addr),
    .st_size(st_size), .st_high_byte(st_high_byte), .st_data(st_data),
    .retire_ok(retire_ok), .ld_valid(ld_valid), .ld_addr(ld_addr), .ld_size(ld_size),
    .st_ready(st_ready), .cache_we(cache_we), .cache_addr(cache_addr),
    .cache_wdata(cache_wdata), .cache_size(cache_size), .cache_rd(cache_rd),
    .load_done(load_done), .load_fwd(load_fwd), .load_stall(load_stall),
    .load_data(load_data));
  slf_core_model core (.clk(clk), .rst(rst), .hold_retire(hold_retire),
    .cache_we(cache_we), .retire_ok(retire_ok), .wr_count(wr_count));
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end
  // ************************************
  // tasks
  // ************************************
  task automatic complete_run();
    if (failures == 0 && comparisons > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask
  task automatic check(input string name, input logic [63:0] exp, input logic [63:0] got);
    comparisons++;
    if (got !== exp) begin
      failures++;
      $display("ERROR %s expected %h seen %h", name, exp, got);
    end
  endtask
  task automatic reset_dut(input int n);
    rst = 1'b1;
    repeat (n) @(posedge clk);
    #1 rst = 1'b0;
  endtask
  // request held until the edge that samples st_ready high
  task automatic do_store(input logic [47:0] a, input slf_pkg::slf_size_t s, input logic hb);
    int n;
    logic ok;
    n = 0;
    st_addr = a; st_size = s; st_high_byte = hb; st_data = DATA; st_valid = 1'b1;
    do begin
      ok = (st_ready === 1'b1);
      @(posedge clk);
      #1 n++;
    end while (!ok && n < 50);
    st_valid = 1'b0;
    if (!ok) begin
      failures++;
      complete_run();
    end
  endtask
  task automatic do_load(input logic [47:0] a, input slf_pkg::slf_size_t s,
                         input logic fwd, input logic dep);
    int n;
    logic stl, done;
    logic [7:0] w0;
    logic [47:0] ca;
    logic [63:0] cd;
    slf_pkg::slf_size_t cs;
    n = 0; stl = 1'b0; done = 1'b0; w0 = wr_count;
    ca = 48'h0;
    cd = 64'h0;
    cs = `SLF_SIZE_1;
    ld_addr = a; ld_size = s; ld_valid = 1'b1;
    while (!done && n < 200) begin
      @(posedge clk);
      #1 n++;
      if (load_stall === 1'b1) stl = 1'b1;
      if (load_done === 1'b1) done = 1'b1;
      if (cache_we === 1'b1) begin
        ca = cache_addr;
        cd = cache_wdata;
        cs = cache_size;
      end
    end
    ld_valid = 1'b0;
    if (!done) begin
      failures++;
      complete_run();
    end else begin
      check("load_fwd", fwd, load_fwd);
      check("cache_rd", !fwd, cache_rd);
      if (fwd) check("load_data", DATA, load_data);
      check("load_stall", dep, stl);
      if (dep) check("cache_write_first", 1, wr_count != w0);
      if (dep) check("cache_addr", st_addr, ca);
      if (dep) check("cache_wdata", DATA, cd);
      if (dep) check("cache_size", st_size, cs);
    end
  endtask
  // ************************************
  // main sequence
  // ************************************
  initial begin
    rst = 1'b1; st_valid = 1'b0; st_addr = 48'h0; st_size = `SLF_SIZE_1;
    st_high_byte = 1'b0; st_data = 64'h0; ld_valid = 1'b0; ld_addr = 48'h0;
    ld_size = `SLF_SIZE_1; hold_retire = 1'b0;
    rows[0] = '{48'h0100, `SLF_SIZE_8, 0, 48'h0100, `SLF_SIZE_8, 1, 0};
    rows[1] = '{48'h0100, `SLF_SIZE_4, 0, 48'h0100, `SLF_SIZE_8, 0, 1};
    rows[2] = '{48'h0100, `SLF_SIZE_4, 0, 48'h0102, `SLF_SIZE_2, 0, 1};
    rows[3] = '{48'h0104, `SLF_SIZE_8, 0, 48'h0104, `SLF_SIZE_8, 0, 1};
    rows[4] = '{48'h0100, `SLF_SIZE_1, 1, 48'h0100, `SLF_SIZE_1, 0, 1};
    rows[5] = '{48'h0100, `SLF_SIZE_8, 0, 48'h0100, `SLF_SIZE_4, 1, 0};
    rows[6] = '{48'h0100, `SLF_SIZE_2, 0, 48'h0104, `SLF_SIZE_2, 0, 0};
    rows[7] = '{48'h0101, `SLF_SIZE_1, 0, 48'h0100, `SLF_SIZE_1, 0, 1};
    rows[8] = '{48'h1100, `SLF_SIZE_4, 0, 48'h0100, `SLF_SIZE_4, 0, 1};
    rows[9] = '{48'h0102, `SLF_SIZE_2, 0, 48'h0102, `SLF_SIZE_1, 1, 0};
    repeat (8) @(posedge clk);
    #1 rst = 1'b0;
    check("st_ready", 1, st_ready);
    check("load_done", 0, load_done);
    check("cache_we", 0, cache_we);
    foreach (rows[i]) begin
      reset_dut(2);
      do_store(rows[i].sa, rows[i].ss, rows[i].hb);
      do_load(rows[i].la, rows[i].ls, rows[i].fwd, rows[i].dep);
    end
    // newest store is a false match and retirement is slow: load must wait it out
    reset_dut(2);
    hold_retire = 1'b1;
    do_store(48'h0100, `SLF_SIZE_1, 1'b0);
    @(posedge clk);
    #1 do_store(48'h0101, `SLF_SIZE_1, 1'b0);
    ld_addr = 48'h0100; ld_size = `SLF_SIZE_1; ld_valid = 1'b1;
    repeat (30) @(posedge clk);
    #1 check("stall_held", 1, load_stall);
    check("no_early_write", 0, wr_count);
    hold_retire = 1'b0;
    do_load(48'h0100, `SLF_SIZE_1, 1'b0, 1'b1);
    complete_run();
  end
endmodule // test_store_load_forward_check
`default_nettype wire
